// [common/ipe_pkg.sv]
package ipe_pkg;
  localparam int         NUM_PRIO          = 6;
  localparam int         NUM_EXT           = 4;
  localparam int         NUM_STAT          = 5;
  localparam logic [5:0] IDX_PRIO_FIRST    = 6'h00;
  localparam logic [5:0] IDX_PRIO_LAST     = 6'h05;
  localparam logic [5:0] IDX_RESET_CAUSE   = 6'h06;
  localparam logic [5:0] IDX_CTRL_FIRST    = 6'h07;
  localparam logic [5:0] IDX_CTRL_SECOND   = 6'h08;
  localparam logic [5:0] IDX_CTRL_THIRD    = 6'h09;
  localparam logic [5:0] IDX_REMAP         = 6'h0a;
  localparam logic [5:0] IDX_STATUS        = 6'h0b;
  localparam logic [5:0] IDX_MASK          = 6'h0c;
  localparam logic [7:0] PRIO_MASK_FULL    = 8'hff;
  localparam logic [7:0] PRIO_MASK_FIFTH   = 8'h77;
  localparam logic [7:0] PRIO_MASK_SIXTH   = 8'hf7;
  localparam int         RC_PRIORITY_LEVELS_ENABLE_BIT       = 7;
  localparam int         RC_CM_BIT         = 5;
  localparam int         RC_RI_BIT         = 4;
  localparam int         RC_TO_BIT         = 3;
  localparam int         RC_PD_BIT         = 2;
  localparam int         RC_POR_BIT        = 1;
  localparam int         RC_BOR_BIT        = 0;
  localparam logic [7:0] RC_RESET          = 8'h3c;
  localparam int         C1_GIE_BIT        = 7;
  localparam int         C1_PERIPHERAL_IRQ_GATE_BIT       = 6;
  localparam int         C1_EN0_BIT        = 4;
  localparam int         C1_FLAG0_BIT      = 1;
  localparam int         C2_EDGE_LSB       = 3;
  localparam int         C2_PRIO3_BIT      = 1;
  localparam int         C3_PRIO2_BIT      = 7;
  localparam int         C3_PRIO1_BIT      = 6;
  localparam int         C3_EN_LSB         = 3;
  localparam int         C3_FLAG_LSB       = 0;
  localparam logic [3:0] EDGE_SEL_RESET    = 4'hf;
  localparam logic [2:0] EXT_PRIO_RESET    = 3'h7;
  localparam logic [11:0] REMAP_RESET      = 12'h0210;
endpackage

// [src/ipe_irq_prio.sv]
`timescale 1ns/1ns
`default_nettype none
module ipe_irq_prio
  import ipe_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [47:0] periph_req_in,
  input  wire logic        port_b_pin_zero_in,
  input  wire logic [7:0]  remap_pins_in,
  input  wire logic        sleep_in,
  input  wire logic        config_mismatch_rst_in,
  input  wire logic        reset_instr_in,
  input  wire logic        watchdog_expired_in,
  output logic             irq_high_out,
  output logic             irq_low_out,
  output logic             wake_out,
  output logic             irq_out
);

  // ****************************************************************
  // Helper functions.
  // ****************************************************************
  function automatic logic [7:0] prio_mask(input logic [5:0] idx);
    if (idx == IDX_PRIO_FIRST + 6'h04)
      prio_mask = PRIO_MASK_FIFTH;
    else if (idx == IDX_PRIO_LAST)
      prio_mask = PRIO_MASK_SIXTH;
    else
      prio_mask = PRIO_MASK_FULL;
  endfunction

  // ****************************************************************
  // State.
  // ****************************************************************
  logic [7:0]          prio_ff [NUM_PRIO];
  logic [7:0]          reset_cause_control_ff;
  logic                gie_ff;
  logic                peripheral_irq_gate_ff;
  logic [3:0]          ext_en_ff;
  logic [3:0]          ext_flag_ff;
  logic [3:0]          edge_sel_ff;
  logic [3:1]          ext_prio_ff;
  logic [11:0]         remap_ff;
  logic [NUM_STAT-1:0] stat_ff;
  logic [NUM_STAT-1:0] mask_ff;
  logic [3:0]          sync1_ff;
  logic [3:0]          sync2_ff;
  logic [3:0]          sync3_ff;
  logic [3:0]          lvl_ff;
  logic                sleep_ff;
  logic [3:0]          sleep_en_ff;
  logic                pready_ff;
  logic                pslverr_ff;
  logic [31:0]         prdata_ff;
  logic                irq_high_ff;
  logic                irq_low_ff;
  logic                wake_ff;
  logic                irq_ff;

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  wire logic [5:0] idx      = paddr_in[7:2];
  wire logic       setup    = psel_in & ~penable_in;
  wire logic       access   = psel_in & penable_in & pready_ff;
  wire logic       wr_en    = access & pwrite_in;
  wire logic       rd_en    = access & ~pwrite_in;
  wire logic       is_prio  = idx <= IDX_PRIO_LAST;
  wire logic       mapped   = idx <= IDX_MASK;
  wire logic       wr_reset_cause_control  = wr_en & (idx == IDX_RESET_CAUSE);
  wire logic       wr_c1    = wr_en & (idx == IDX_CTRL_FIRST);
  wire logic       wr_c2    = wr_en & (idx == IDX_CTRL_SECOND);
  wire logic       wr_c3    = wr_en & (idx == IDX_CTRL_THIRD);
  wire logic       wr_remap = wr_en & (idx == IDX_REMAP);
  wire logic       wr_mask  = wr_en & (idx == IDX_MASK);
  wire logic       rd_stat  = rd_en & (idx == IDX_STATUS);
  wire logic [7:0] wd       = pwdata_in[7:0];

  // ****************************************************************
  // External pins: remap, three-stage synchroniser, edge detect.
  // ****************************************************************
  wire logic [3:0] raw_pins = {
    remap_pins_in[remap_ff[10:8]],
    remap_pins_in[remap_ff[6:4]],
    remap_pins_in[remap_ff[2:0]],
    port_b_pin_zero_in
  };
  wire logic [3:0] settled  = ~(sync2_ff ^ sync3_ff);
  wire logic [3:0] nxt_lvl  = (settled & sync3_ff) | (~settled & lvl_ff);
  wire logic [3:0] edge_ev  = (nxt_lvl ^ lvl_ff)
                            & ~(nxt_lvl ^ edge_sel_ff);

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      sync3_ff <= 4'h0;
      lvl_ff   <= 4'h0;
    end
    else
    begin
      sync1_ff <= raw_pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      lvl_ff   <= nxt_lvl;
    end
  end

  // ****************************************************************
  // External flags, enables and control registers.
  // ****************************************************************
  wire logic [3:0] wr_flag_val = {wd[C3_FLAG_LSB +: 3], wd[C1_FLAG0_BIT]};
  wire logic [3:0] wr_flag_sel = {{3{wr_c3}}, wr_c1};
  wire logic [3:0] nxt_flag    = edge_ev
    | (wr_flag_sel & wr_flag_val) | (~wr_flag_sel & ext_flag_ff);

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ext_flag_ff <= 4'h0;
      ext_en_ff   <= 4'h0;
      edge_sel_ff <= EDGE_SEL_RESET;
      ext_prio_ff <= EXT_PRIO_RESET;
      gie_ff      <= 1'b0;
      peripheral_irq_gate_ff     <= 1'b0;
      remap_ff    <= REMAP_RESET;
    end
    else
    begin
      ext_flag_ff <= nxt_flag;
      if (wr_c1)
      begin
        gie_ff       <= wd[C1_GIE_BIT];
        peripheral_irq_gate_ff      <= wd[C1_PERIPHERAL_IRQ_GATE_BIT];
        ext_en_ff[0] <= wd[C1_EN0_BIT];
      end
      if (wr_c2)
      begin
        edge_sel_ff    <= wd[C2_EDGE_LSB +: 4];
        ext_prio_ff[3] <= wd[C2_PRIO3_BIT];
      end
      if (wr_c3)
      begin
        ext_prio_ff[2]   <= wd[C3_PRIO2_BIT];
        ext_prio_ff[1]   <= wd[C3_PRIO1_BIT];
        ext_en_ff[3:1]   <= wd[C3_EN_LSB +: 3];
      end
      if (wr_remap)
        remap_ff <= pwdata_in[11:0];
    end
  end

  // ****************************************************************
  // Peripheral priority registers.
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < NUM_PRIO; i++)
        prio_ff[i] <= prio_mask(6'(i));
    end
    else if (wr_en && is_prio)
      prio_ff[idx[2:0]] <= wd & prio_mask(idx);
  end

  wire logic [47:0] prio_vec = {prio_ff[5], prio_ff[4], prio_ff[3],
                                prio_ff[2], prio_ff[1], prio_ff[0]};
  wire logic [47:0] impl_vec = {PRIO_MASK_SIXTH, PRIO_MASK_FIFTH,
                                {4{PRIO_MASK_FULL}}};

  // ****************************************************************
  // Reset cause and priority enable register.
  // ****************************************************************
  wire logic sleep_rise = sleep_in & ~sleep_ff;
  wire logic [7:0] rc_wr = wr_reset_cause_control ? wd : reset_cause_control_ff;

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      reset_cause_control_ff <= RC_RESET;
    else
    begin
      reset_cause_control_ff[RC_PRIORITY_LEVELS_ENABLE_BIT] <= rc_wr[RC_PRIORITY_LEVELS_ENABLE_BIT];
      reset_cause_control_ff[6]           <= 1'b0;
      reset_cause_control_ff[RC_CM_BIT]   <= rc_wr[RC_CM_BIT]
                              & ~config_mismatch_rst_in;
      reset_cause_control_ff[RC_RI_BIT]   <= rc_wr[RC_RI_BIT] & ~reset_instr_in;
      reset_cause_control_ff[RC_TO_BIT]   <= reset_cause_control_ff[RC_TO_BIT]
                              & ~watchdog_expired_in;
      reset_cause_control_ff[RC_PD_BIT]   <= reset_cause_control_ff[RC_PD_BIT] & ~sleep_rise;
      reset_cause_control_ff[RC_POR_BIT]  <= rc_wr[RC_POR_BIT];
      reset_cause_control_ff[RC_BOR_BIT]  <= rc_wr[RC_BOR_BIT];
    end
  end

  wire logic priority_levels_enable = reset_cause_control_ff[RC_PRIORITY_LEVELS_ENABLE_BIT];

  // ****************************************************************
  // Requests toward the core and wake-up.
  // ****************************************************************
  wire logic [47:0] per_req  = periph_req_in & impl_vec;
  wire logic [3:0]  ext_act  = ext_flag_ff & ext_en_ff;
  wire logic [3:0]  ext_hi   = {ext_prio_ff, 1'b1};
  wire logic per_hi  = |(per_req & prio_vec);
  wire logic per_lo  = |(per_req & ~prio_vec);
  wire logic two_hi  = per_hi | |(ext_act & ext_hi);
  wire logic two_lo  = per_lo | |(ext_act & ~ext_hi);
  wire logic one_req = |ext_act | (peripheral_irq_gate_ff & |per_req);
  wire logic nxt_hi  = gie_ff & (priority_levels_enable ? two_hi : one_req);
  wire logic nxt_lo  = gie_ff & peripheral_irq_gate_ff & priority_levels_enable & two_lo;
  wire logic nxt_wake = sleep_in & |(ext_flag_ff & sleep_en_ff);

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sleep_ff    <= 1'b0;
      sleep_en_ff <= 4'h0;
      irq_high_ff <= 1'b0;
      irq_low_ff  <= 1'b0;
      wake_ff     <= 1'b0;
    end
    else
    begin
      sleep_ff <= sleep_in;
      if (sleep_rise)
        sleep_en_ff <= ext_en_ff;
      irq_high_ff <= nxt_hi;
      irq_low_ff  <= nxt_lo;
      wake_ff     <= nxt_wake;
    end
  end

  // ****************************************************************
  // Sticky event status, mask and interrupt line.
  // ****************************************************************
  wire logic [NUM_STAT-1:0] stat_ev  = {config_mismatch_rst_in, edge_ev};
  wire logic [NUM_STAT-1:0] nxt_stat = stat_ev
                                     | (rd_stat ? '0 : stat_ff);

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      stat_ff <= '0;
      mask_ff <= '0;
      irq_ff  <= 1'b0;
    end
    else
    begin
      stat_ff <= nxt_stat;
      if (wr_mask)
        mask_ff <= pwdata_in[NUM_STAT-1:0];
      irq_ff  <= |(nxt_stat & mask_ff);
    end
  end

  // ****************************************************************
  // Read data and bus answer.
  // ****************************************************************
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (is_prio)
      rd_byte = prio_ff[idx[2:0]];
    else if (idx == IDX_RESET_CAUSE)
      rd_byte = reset_cause_control_ff;
    else if (idx == IDX_CTRL_FIRST)
      rd_byte = {gie_ff, peripheral_irq_gate_ff, 1'b0, ext_en_ff[0],
                 2'b00, ext_flag_ff[0], 1'b0};
    else if (idx == IDX_CTRL_SECOND)
      rd_byte = {1'b0, edge_sel_ff, 1'b0, ext_prio_ff[3], 1'b0};
    else if (idx == IDX_CTRL_THIRD)
      rd_byte = {ext_prio_ff[2], ext_prio_ff[1],
                 ext_en_ff[3:1], ext_flag_ff[3:1]};
    else if (idx == IDX_STATUS)
      rd_byte = {3'b000, stat_ff};
    else if (idx == IDX_MASK)
      rd_byte = {3'b000, mask_ff};
  end

  wire logic [31:0] rd_word = (idx == IDX_REMAP) ? {20'h0_0000, remap_ff}
                                                 : {24'h00_0000, rd_byte};

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup)
        prdata_ff <= mapped ? rd_word : 32'h0000_0000;
    end
  end

  assign prdata_out   = prdata_ff;
  assign pready_out   = pready_ff;
  assign pslverr_out  = pslverr_ff;
  assign irq_high_out = irq_high_ff;
  assign irq_low_out  = irq_low_ff;
  assign wake_out     = wake_ff;
  assign irq_out      = irq_ff;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence prio0_write_s;
    wr_en && idx == IDX_PRIO_FIRST;
  endsequence

  low_needs_priority_levels_enable_a: assert property (
    irq_low_out |-> $past(priority_levels_enable)) else $error("low request without priority_levels_enable");
  prio_write_a: assert property (
    prio0_write_s |=> prio_ff[0] == $past(wd))
    else $error("priority write lost");
  rsvd_zero_a: assert property (
    prio_ff[4][7] == 1'b0 && prio_ff[4][3] == 1'b0 && prio_ff[5][3] == 1'b0)
    else $error("reserved priority bit set");
  cm_clear_a: assert property (
    config_mismatch_rst_in |=> !reset_cause_control_ff[RC_CM_BIT])
    else $error("mismatch flag not cleared");
  edge_polarity_a: assert property (
    edge_ev[0] |=> lvl_ff[0] == $past(edge_sel_ff[0]))
    else $error("edge of wrong polarity");
  flag_set_a: assert property (
    edge_ev[1] |=> ext_flag_ff[1]) else $error("edge did not set flag");
  ext0_high_a: assert property (
    priority_levels_enable && gie_ff && ext_act[0] |=> irq_high_out)
    else $error("input zero not high priority");
  wake_up_a: assert property (
    sleep_in && |(ext_flag_ff & sleep_en_ff) |=> wake_out)
    else $error("wake not raised");
  single_gate_a: assert property (
    !priority_levels_enable && !gie_ff |=> !irq_high_out ##0 !irq_low_out)
    else $error("request with global enable off");
  peripheral_irq_gate_gate_a: assert property (
    !priority_levels_enable && !peripheral_irq_gate_ff && !(|ext_act) |=> !irq_high_out)
    else $error("peripheral request passed without gate");

endmodule
`default_nettype wire

// [dv/ipe_pin_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// External pin drivers seen by the block.
// ****************************************
module ipe_pin_model
(
  input  wire logic       core_clk_in,
  output logic            pin_zero_out,
  output logic [7:0]      remap_pins_out
);
  initial
  begin
    pin_zero_out   = 1'b0;
    remap_pins_out = 8'h00;
  end

  // Moves one pin just after a rising edge; index 8 is port B pin zero.
  task automatic move(input int idx, input logic lvl);
    @(posedge core_clk_in);
    if (idx == 8)
      pin_zero_out <= lvl;
    else
      remap_pins_out[idx] <= lvl;
  endtask
endmodule
`default_nettype wire

// [dv/interrupt_priority_and_external_edges_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) \
  begin \
    n_checks++; \
    if ((gt) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("unexpected %s exp %h got %h", nm, ex, gt); \
    end \
  end
// ****************************************
// Self-checking bench for the priority block.
// ****************************************
module interrupt_priority_and_external_edges_tb;
  import ipe_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [11:0] d;
                         logic [11:0] x; logic e;} ipe_row_t;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [47:0] preq = 48'h0000_0000_0000;
  logic        sleep = 1'b0;
  logic        cfg = 1'b0;
  logic        rinst = 1'b0;
  logic        wdog = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, er, hi, lo, wake, irq, pin0;
  logic [7:0]  rpins;
  int          n_mismatch = 0;
  int          n_checks = 0;
  ipe_row_t    rows [21];

  ipe_irq_prio ipe_irq_prio_i
  (
    .core_clk_in            (clk),
    .rst_b_in               (rst_b),
    .psel_in                (psel),
    .penable_in             (penable),
    .pwrite_in              (pwrite),
    .paddr_in               (paddr),
    .pwdata_in              (pwdata),
    .prdata_out             (prdata),
    .pready_out             (pready),
    .pslverr_out            (pslverr),
    .periph_req_in          (preq),
    .port_b_pin_zero_in     (pin0),
    .remap_pins_in          (rpins),
    .sleep_in               (sleep),
    .config_mismatch_rst_in (cfg),
    .reset_instr_in         (rinst),
    .watchdog_expired_in    (wdog),
    .irq_high_out           (hi),
    .irq_low_out            (lo),
    .wake_out               (wake),
    .irq_out                (irq)
  );

  ipe_pin_model ipe_pin_model_i
  (
    .core_clk_in    (clk),
    .pin_zero_out   (pin0),
    .remap_pins_out (rpins)
  );

  always #25 clk = ~clk;

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("prdata", x, rd)
  endtask

  task automatic settle;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic print_verdict;
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #(50 * 5000);
    n_mismatch++;
    print_verdict;
  end

  initial
  begin
    rows = '{
      '{1'b0, 8'h00, 12'h000, 12'h0ff, 1'b0},
      '{1'b0, 8'h04, 12'h000, 12'h0ff, 1'b0},
      '{1'b0, 8'h08, 12'h000, 12'h0ff, 1'b0},
      '{1'b0, 8'h0c, 12'h000, 12'h0ff, 1'b0},
      '{1'b0, 8'h10, 12'h000, 12'h077, 1'b0},
      '{1'b0, 8'h14, 12'h000, 12'h0f7, 1'b0},
      '{1'b0, 8'h18, 12'h000, 12'h03c, 1'b0},
      '{1'b0, 8'h1c, 12'h000, 12'h000, 1'b0},
      '{1'b0, 8'h20, 12'h000, 12'h07a, 1'b0},
      '{1'b0, 8'h24, 12'h000, 12'h0c0, 1'b0},
      '{1'b0, 8'h28, 12'h000, 12'h210, 1'b0},
      '{1'b1, 8'h10, 12'h0ff, 12'h077, 1'b0},
      '{1'b1, 8'h14, 12'h000, 12'h000, 1'b0},
      '{1'b1, 8'h14, 12'h0ff, 12'h0f7, 1'b0},
      '{1'b1, 8'h00, 12'h05a, 12'h05a, 1'b0},
      '{1'b1, 8'h18, 12'h0ff, 12'h0bf, 1'b0},
      '{1'b1, 8'h18, 12'h000, 12'h00c, 1'b0},
      '{1'b1, 8'h18, 12'h030, 12'h03c, 1'b0},
      '{1'b1, 8'h28, 12'h765, 12'h765, 1'b0},
      '{1'b1, 8'h28, 12'h210, 12'h210, 1'b0},
      '{1'b1, 8'h34, 12'h0ff, 12'h000, 1'b1}
    };
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    settle;
    `CHK("irq_high", 1'b0, hi)
    `CHK("wake", 1'b0, wake)
    foreach (rows[i])
    begin
      if (rows[i].w)
        apb(1'b1, rows[i].a, {20'h0_0000, rows[i].d});
      apb(1'b0, rows[i].a, 32'h0000_0000);
      `CHK("prdata", {20'h0_0000, rows[i].x}, rd)
      `CHK("pslverr", rows[i].e, er)
    end
    apb(1'b1, 8'h1c, 32'h0000_0090);
    ipe_pin_model_i.move(8, 1'b1);
    settle;
    `CHK("irq_high", 1'b1, hi)
    `CHK("irq_low", 1'b0, lo)
    rd_chk(8'h1c, 32'h0000_0092);
    apb(1'b1, 8'h1c, 32'h0000_0090);
    settle;
    `CHK("irq_high", 1'b0, hi)
    apb(1'b1, 8'h20, 32'h0000_0002);
    ipe_pin_model_i.move(8, 1'b0);
    settle;
    rd_chk(8'h1c, 32'h0000_0092);
    apb(1'b1, 8'h1c, 32'h0000_0090);
    apb(1'b1, 8'h30, 32'h0000_0000);
    settle;
    `CHK("irq", 1'b0, irq)
    apb(1'b1, 8'h30, 32'h0000_0001);
    settle;
    `CHK("irq", 1'b1, irq)
    rd_chk(8'h2c, 32'h0000_0001);
    settle;
    `CHK("irq", 1'b0, irq)
    apb(1'b1, 8'h18, 32'h0000_00bc);
    apb(1'b1, 8'h1c, 32'h0000_00d0);
    apb(1'b1, 8'h24, 32'h0000_0088);
    ipe_pin_model_i.move(0, 1'b1);
    settle;
    ipe_pin_model_i.move(0, 1'b0);
    settle;
    `CHK("irq_low", 1'b1, lo)
    `CHK("irq_high", 1'b0, hi)
    apb(1'b1, 8'h24, 32'h0000_0088);
    @(posedge clk);
    preq <= 48'h0000_0000_0001;
    settle;
    `CHK("irq_low", 1'b1, lo)
    `CHK("irq_high", 1'b0, hi)
    apb(1'b1, 8'h18, 32'h0000_003c);
    settle;
    `CHK("irq_high", 1'b1, hi)
    `CHK("irq_low", 1'b0, lo)
    apb(1'b1, 8'h1c, 32'h0000_0090);
    settle;
    `CHK("irq_high", 1'b0, hi)
    @(posedge clk);
    preq <= 48'h0000_0000_0000;
    ipe_pin_model_i.move(8, 1'b1);
    @(posedge clk);
    sleep <= 1'b1;
    settle;
    ipe_pin_model_i.move(8, 1'b0);
    settle;
    `CHK("wake", 1'b1, wake)
    `CHK("irq_high", 1'b1, hi)
    @(posedge clk);
    sleep <= 1'b0;
    apb(1'b1, 8'h1c, 32'h0000_0090);
    @(posedge clk);
    cfg <= 1'b1;
    @(posedge clk);
    cfg <= 1'b0;
    rinst <= 1'b1;
    @(posedge clk);
    rinst <= 1'b0;
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    rd_chk(8'h18, 32'h0000_0000);
    rd_chk(8'h2c, 32'h0000_0013);
    apb(1'b1, 8'h18, 32'h0000_0020);
    rd_chk(8'h18, 32'h0000_0020);
    apb(1'b1, 8'h18, 32'h0000_00a0);
    apb(1'b1, 8'h1c, 32'h0000_0092);
    settle;
    `CHK("irq_high", 1'b1, hi)
    `CHK("irq_low", 1'b0, lo)
    @(posedge clk);
    rst_b <= 1'b0;
    settle;
    `CHK("irq", 1'b0, irq)
    @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(8'h18, 32'h0000_003c);
    print_verdict;
  end
endmodule
`default_nettype wire
